// >>> hw/spc_pkg.sv
`default_nettype none
package spc_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned CMD_W         = 16;
  localparam logic [15:0] CMD_OFF       = 16'h0004;

  // command field positions
  localparam int unsigned CMD_IO_BIT    = 0;
  localparam int unsigned CMD_MEM_BIT   = 1;
  localparam int unsigned CMD_BME_BIT   = 2;
  localparam int unsigned CMD_PER_BIT   = 6;
  localparam int unsigned CMD_SERR_BIT  = 8;
  localparam int unsigned CMD_INTD_BIT  = 10;

  // writable bits: 0,1,2,6,8,10; everything else reads zero
  localparam logic [15:0] CMD_WMASK     = 16'h0547;
  localparam logic [15:0] CMD_RST       = 16'h0000;

  // status flags in the upper half of the same word
  localparam int unsigned STS_MDPE_BIT  = 24;
  localparam int unsigned STS_SSE_BIT   = 30;
  localparam int unsigned STS_LANE      = 3;

  // -----------------------------------------------------------------
  // state types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cmd;
    logic        sts_mdpe;
    logic        sts_sse;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        err_fatal;
    logic        err_nonfatal;
    logic        parity_handle;
    logic        intx_own;
    logic        intx_fwd;
  } spc_state_type;

  localparam spc_state_type ST_RST = '{cmd: CMD_RST, default: '0};

  typedef struct packed {
    logic pri_io_ack;
    logic pri_mem_ack;
    logic up_fwd;
    logic ur_cpl;
    logic up_own;
  } spc_gate_type;

  localparam spc_gate_type GATE_RST = '0;

endpackage
`default_nettype wire

// >>> hw/spc_req_gate.sv
`timescale 1ns/100ps
`default_nettype none
module spc_req_gate (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_io_en,
  input  wire logic i_mem_en,
  input  wire logic i_bme,
  input  wire logic i_pri_io_req,
  input  wire logic i_pri_mem_req,
  input  wire logic i_dn_req,
  input  wire logic i_dn_np,
  input  wire logic i_own_req,
  output logic      o_pri_io_ack,
  output logic      o_pri_mem_ack,
  output logic      o_up_fwd,
  output logic      o_ur_cpl,
  output logic      o_up_own
);
  import spc_pkg::*;

  spc_gate_type g_r;
  spc_gate_type g_nxt;

  // -----------------------------------------------------------------
  // request gating
  // -----------------------------------------------------------------
  always_comb begin
    g_nxt             = GATE_RST;
    g_nxt.pri_io_ack  = i_pri_io_req & i_io_en;
    g_nxt.pri_mem_ack = i_pri_mem_req & i_mem_en;
    g_nxt.up_own      = i_own_req & i_bme;
    g_nxt.up_fwd      = i_dn_req & i_bme;
    g_nxt.ur_cpl      = i_dn_req & i_dn_np & ~i_bme;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      g_r <= GATE_RST;
    end else begin
      g_r <= g_nxt;
    end
  end

  assign o_pri_io_ack  = g_r.pri_io_ack;
  assign o_pri_mem_ack = g_r.pri_mem_ack;
  assign o_up_fwd      = g_r.up_fwd;
  assign o_ur_cpl      = g_r.ur_cpl;
  assign o_up_own      = g_r.up_own;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_io_gate_resp: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_pri_io_req |=> (o_pri_io_ack == $past(i_io_en)))
    else $error("io request answer does not follow io enable");
  a_mem_gate_resp: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_pri_mem_req |=> (o_pri_mem_ack == $past(i_mem_en)))
    else $error("memory request answer does not follow memory enable");
  a_own_req_block: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_up_own |-> $past(i_bme) && $past(i_own_req))
    else $error("upstream request issued with bus master off");
  a_ur_on_np: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_dn_req && !i_bme) |=> !o_up_fwd && (o_ur_cpl == $past(i_dn_np)))
    else $error("downstream request not treated as unsupported");
  a_fwd_upstream: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_dn_req && i_bme) |=> o_up_fwd && !o_ur_cpl)
    else $error("downstream request not forwarded");
  c_ur_cpl: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_ur_cpl);
endmodule // spc_req_gate
`default_nettype wire

// >>> hw/spc_cmd_reg.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module spc_cmd_reg #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // request path
  input  wire logic              i_pri_io_req,
  input  wire logic              i_pri_mem_req,
  input  wire logic              i_dn_req,
  input  wire logic              i_dn_np,
  input  wire logic              i_own_req,
  output logic                   o_pri_io_ack,
  output logic                   o_pri_mem_ack,
  output logic                   o_up_fwd,
  output logic                   o_ur_cpl,
  output logic                   o_up_own,
  // errors
  input  wire logic              i_parity_err,
  input  wire logic              i_pri_mdpe,
  input  wire logic              i_err_fatal,
  input  wire logic              i_err_nonfatal,
  output logic                   o_parity_handle,
  output logic                   o_err_fatal_msg,
  output logic                   o_err_nonfatal_msg,
  // legacy interrupts
  input  wire logic              i_intx_own,
  input  wire logic              i_intx_dn,
  output logic                   o_intx_own,
  output logic                   o_intx_fwd,
  // enable levels for the datapath
  output logic                   o_io_en,
  output logic                   o_mem_en,
  output logic                   o_bme,
  output logic                   o_per_en,
  output logic                   o_serr_en,
  output logic                   o_intx_dis
);
  import spc_pkg::*;

  spc_state_type st_r;
  spc_state_type st_nxt;
  logic          setup;
  logic          acc_wr;
  logic [31:0]   rd_word;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  function automatic logic cmd_hit(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2] == CMD_OFF[ADDR_W-1:2];
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    setup  = i_psel & ~i_penable;
    acc_wr = i_psel & i_penable & st_r.pready & i_pwrite & cmd_hit(i_paddr);
    rd_word = {16'h0000, st_r.cmd & CMD_WMASK};
    rd_word[STS_MDPE_BIT] = st_r.sts_mdpe;
    rd_word[STS_SSE_BIT]  = st_r.sts_sse;

    // one wait-free access phase: pready rises the cycle after setup
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & ~cmd_hit(i_paddr);
    st_nxt.prdata  = (setup & ~i_pwrite & cmd_hit(i_paddr)) ? rd_word : 32'h0000_0000;

    if (acc_wr) begin
      if (i_pstrb[0]) begin
        st_nxt.cmd[7:0] = i_pwdata[7:0] & CMD_WMASK[7:0];
      end
      if (i_pstrb[1]) begin
        st_nxt.cmd[15:8] = i_pwdata[15:8] & CMD_WMASK[15:8];
      end
      if (i_pstrb[STS_LANE] && i_pwdata[STS_MDPE_BIT]) begin
        st_nxt.sts_mdpe = 1'b0;
      end
      if (i_pstrb[STS_LANE] && i_pwdata[STS_SSE_BIT]) begin
        st_nxt.sts_sse = 1'b0;
      end
    end

    // error messages and parity handling
    st_nxt.err_fatal     = i_err_fatal & st_r.cmd[CMD_SERR_BIT];
    st_nxt.err_nonfatal  = i_err_nonfatal & st_r.cmd[CMD_SERR_BIT];
    st_nxt.parity_handle = i_parity_err & st_r.cmd[CMD_PER_BIT];

    // set wins over a same-cycle clear
    if (st_nxt.err_fatal || st_nxt.err_nonfatal) begin
      st_nxt.sts_sse = 1'b1;
    end
    if (i_pri_mdpe && st_r.cmd[CMD_PER_BIT]) begin
      st_nxt.sts_mdpe = 1'b1;
    end

    st_nxt.intx_own = i_intx_own & ~st_r.cmd[CMD_INTD_BIT];
    st_nxt.intx_fwd = i_intx_dn;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------
  // request gating
  // -----------------------------------------------------------------
  spc_req_gate u_gate (
    .i_mclk        (i_mclk),
    .i_rstn        (i_rstn),
    .i_io_en       (st_r.cmd[CMD_IO_BIT]),
    .i_mem_en      (st_r.cmd[CMD_MEM_BIT]),
    .i_bme         (st_r.cmd[CMD_BME_BIT]),
    .i_pri_io_req  (i_pri_io_req),
    .i_pri_mem_req (i_pri_mem_req),
    .i_dn_req      (i_dn_req),
    .i_dn_np       (i_dn_np),
    .i_own_req     (i_own_req),
    .o_pri_io_ack  (o_pri_io_ack),
    .o_pri_mem_ack (o_pri_mem_ack),
    .o_up_fwd      (o_up_fwd),
    .o_ur_cpl      (o_ur_cpl),
    .o_up_own      (o_up_own)
  );

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign o_prdata           = st_r.prdata;
  assign o_pready           = st_r.pready;
  assign o_pslverr          = st_r.pslverr;
  assign o_parity_handle    = st_r.parity_handle;
  assign o_err_fatal_msg    = st_r.err_fatal;
  assign o_err_nonfatal_msg = st_r.err_nonfatal;
  assign o_intx_own         = st_r.intx_own;
  assign o_intx_fwd         = st_r.intx_fwd;
  assign o_io_en            = st_r.cmd[CMD_IO_BIT];
  assign o_mem_en           = st_r.cmd[CMD_MEM_BIT];
  assign o_bme              = st_r.cmd[CMD_BME_BIT];
  assign o_per_en           = st_r.cmd[CMD_PER_BIT];
  assign o_serr_en          = st_r.cmd[CMD_SERR_BIT];
  assign o_intx_dis         = st_r.cmd[CMD_INTD_BIT];

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_legacy_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_pready && o_prdata != 32'h0000_0000 |-> o_prdata[9] == 1'b0 && o_prdata[7] == 1'b0
      && o_prdata[5:3] == 3'h0)
    else $error("legacy command bit reads nonzero");

  a_rsvd_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (st_r.cmd & ~CMD_WMASK) == 16'h0000 && o_prdata[15:11] == 5'h00)
    else $error("reserved command bits nonzero");

  a_cmd_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_psel && i_penable && o_pready && i_pwrite && cmd_hit(i_paddr) && i_pstrb[0])
      |=> st_r.cmd[7:0] == ($past(i_pwdata[7:0]) & CMD_WMASK[7:0]))
    else $error("command low byte not written");

  a_apb_answer: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_psel && !i_penable) |=> o_pready ##1 !o_pready)
    else $error("apb access phase not one cycle");

  a_parity_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_parity_err |=> (o_parity_handle == $past(st_r.cmd[CMD_PER_BIT])))
    else $error("parity handling does not follow parity response");

  a_err_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (o_err_fatal_msg || o_err_nonfatal_msg) |-> $past(st_r.cmd[CMD_SERR_BIT]))
    else $error("error message sent while reporting disabled");

  a_err_pass: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_err_fatal && st_r.cmd[CMD_SERR_BIT]) |=> o_err_fatal_msg)
    else $error("fatal error not reported while enabled");

  a_intx_own: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_intx_own |=> (o_intx_own == !$past(st_r.cmd[CMD_INTD_BIT])))
    else $error("own INTx does not follow interrupt disable");

  a_intx_forward: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_intx_dn && st_r.cmd[CMD_INTD_BIT] |=> o_intx_fwd)
    else $error("downstream INTx blocked by interrupt disable");

  a_sse_cause: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(st_r.sts_sse) |-> (o_err_fatal_msg || o_err_nonfatal_msg))
    else $error("system error flag set without a sent message");

  a_sse_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_psel && i_penable && o_pready && i_pwrite && cmd_hit(i_paddr) && i_pstrb[STS_LANE]
      && i_pwdata[STS_SSE_BIT] && !i_err_fatal && !i_err_nonfatal) |=> !st_r.sts_sse)
    else $error("system error flag not cleared by write of one");

  a_mdpe_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !st_r.cmd[CMD_PER_BIT] && !st_r.sts_mdpe |=> !st_r.sts_mdpe)
    else $error("parity status set while parity response off");

  a_bme_upstream: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !st_r.cmd[CMD_BME_BIT] [*2] |-> !o_up_own && !o_up_fwd)
    else $error("upstream traffic with bus master off");

  a_cmd_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !acc_wr |=> $stable(st_r.cmd))
    else $error("command changed without a write");

  a_lane_keep: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    acc_wr && !i_pstrb[0] && !i_pstrb[1] |=> $stable(st_r.cmd))
    else $error("command changed by a status lane write");

  a_cmd_high: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    acc_wr && i_pstrb[1] |=> st_r.cmd[15:8] == ($past(i_pwdata[15:8]) & CMD_WMASK[15:8]))
    else $error("command high byte not written");

  a_read_back: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    setup && !i_pwrite && cmd_hit(i_paddr) |=> o_prdata[15:0] == $past(st_r.cmd) && !o_pslverr)
    else $error("command read data wrong");

  a_read_status: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    setup && !i_pwrite && cmd_hit(i_paddr) |=> o_prdata[STS_SSE_BIT] == $past(st_r.sts_sse)
      && o_prdata[STS_MDPE_BIT] == $past(st_r.sts_mdpe))
    else $error("status read data wrong");

  a_unmapped_refuse: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    setup && !cmd_hit(i_paddr) |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_idle_ready: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !setup |=> !o_pready && !o_pslverr)
    else $error("apb answer without a setup cycle");

  a_nonfatal_pass: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_err_nonfatal && st_r.cmd[CMD_SERR_BIT]) |=> o_err_nonfatal_msg)
    else $error("nonfatal error not reported while enabled");

  a_serr_block: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !st_r.cmd[CMD_SERR_BIT] |=> !o_err_fatal_msg && !o_err_nonfatal_msg)
    else $error("error message sent with reporting off");

  a_parity_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !st_r.cmd[CMD_PER_BIT] |=> !o_parity_handle)
    else $error("parity handling with parity response off");

  a_sse_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !st_r.cmd[CMD_SERR_BIT] && !st_r.sts_sse |=> !st_r.sts_sse)
    else $error("system error flag set with reporting off");

  a_sse_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_err_fatal || i_err_nonfatal) && st_r.cmd[CMD_SERR_BIT] |=> st_r.sts_sse)
    else $error("system error flag not set by a sent message");

  a_sse_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    st_r.sts_sse && !(acc_wr && i_pstrb[STS_LANE] && i_pwdata[STS_SSE_BIT]) |=> st_r.sts_sse)
    else $error("system error flag lost without a clear");

  a_mdpe_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_pri_mdpe && st_r.cmd[CMD_PER_BIT] |=> st_r.sts_mdpe)
    else $error("parity status not set while response on");

  a_mdpe_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    acc_wr && i_pstrb[STS_LANE] && i_pwdata[STS_MDPE_BIT] && !i_pri_mdpe |=> !st_r.sts_mdpe)
    else $error("parity status not cleared by write of one");

  a_mdpe_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    st_r.sts_mdpe && !(acc_wr && i_pstrb[STS_LANE] && i_pwdata[STS_MDPE_BIT]) |=> st_r.sts_mdpe)
    else $error("parity status lost without a clear");

  a_intx_block: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    st_r.cmd[CMD_INTD_BIT] |=> !o_intx_own)
    else $error("own INTx sent while interrupts disabled");

  a_intx_follow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    1'b1 |=> o_intx_fwd == $past(i_intx_dn))
    else $error("downstream INTx not forwarded as received");

  c_bme_set: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(st_r.cmd[CMD_BME_BIT]));
  c_sse_set: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(st_r.sts_sse));
  c_mdpe_set: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(st_r.sts_mdpe));
  c_slverr: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_pslverr);
endmodule // spc_cmd_reg
`default_nettype wire

// >>> dv/spc_rc_model.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------
// root complex side: issues configuration accesses as apb requester
// -----------------------------------------------------------------
module spc_rc_model (
  input  wire logic        i_mclk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [11:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  output logic [3:0]       o_pstrb
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0;
    o_pstrb   = 4'h0;
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge i_mclk);
    o_psel   <= 1'b1;
    o_pwrite <= w;
    o_paddr  <= a;
    o_pwdata <= d;
    o_pstrb  <= s;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_mclk);
    end while (i_pready !== 1'b1);
    rd = i_prdata;
    err = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    // released address and data lines never keep the last value
    o_paddr   <= ~a;
    o_pwdata  <= ~d;
  endtask
endmodule // spc_rc_model
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  import spc_pkg::*;
  logic        i_mclk, i_rstn, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0]  i_pstrb;
  logic [10:0] req_v;
  wire logic   i_pri_io_req, i_pri_mem_req, i_dn_req, i_dn_np, i_own_req, i_parity_err, i_pri_mdpe;
  wire logic   i_err_fatal, i_err_nonfatal, i_intx_own, i_intx_dn;
  logic        o_pri_io_ack, o_pri_mem_ack, o_up_fwd, o_ur_cpl, o_up_own, o_parity_handle;
  logic        o_err_fatal_msg, o_err_nonfatal_msg, o_intx_own, o_intx_fwd;
  logic        o_io_en, o_mem_en, o_bme, o_per_en, o_serr_en, o_intx_dis;
  int          err_total = 0;
  int          n_compared = 0;
  int          cycles = 0;

  assign {i_pri_io_req, i_pri_mem_req, i_dn_req, i_dn_np, i_own_req, i_parity_err, i_pri_mdpe,
          i_err_fatal, i_err_nonfatal, i_intx_own, i_intx_dn} = req_v;

  spc_cmd_reg #(.ADDR_W(12)) dut (
    .i_mclk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
    .o_prdata, .o_pready, .o_pslverr, .i_pri_io_req, .i_pri_mem_req, .i_dn_req, .i_dn_np,
    .i_own_req, .o_pri_io_ack, .o_pri_mem_ack, .o_up_fwd, .o_ur_cpl, .o_up_own,
    .i_parity_err, .i_pri_mdpe, .i_err_fatal, .i_err_nonfatal, .o_parity_handle,
    .o_err_fatal_msg, .o_err_nonfatal_msg, .i_intx_own, .i_intx_dn, .o_intx_own, .o_intx_fwd,
    .o_io_en, .o_mem_en, .o_bme, .o_per_en, .o_serr_en, .o_intx_dis
  );

  spc_rc_model u_rc (
    .i_mclk(i_mclk), .i_prdata(o_prdata), .i_pready(o_pready), .i_pslverr(o_pslverr),
    .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
    .o_pwdata(i_pwdata), .o_pstrb(i_pstrb)
  );

  // -----------------------------------------------------------------
  // clock, timeout and verdict
  // -----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end

  // -----------------------------------------------------------------
  // register access helpers
  // -----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        er;
    u_rc.xfer(1'b1, a, d, s, rd, er);
    `CHK("wr_pslverr", a[11:2] != CMD_OFF[11:2], er)
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] rd;
    logic        er;
    u_rc.xfer(1'b0, a, 32'h0, 4'h0, rd, er);
    `CHK("prdata", exp, rd)
    `CHK("pslverr", e, er)
  endtask

  // -----------------------------------------------------------------
  // one command value: readback, gating of every path, status flags
  // -----------------------------------------------------------------
  task automatic req_chk(input logic [15:0] c);
    logic [15:0] ce;
    ce = c & CMD_WMASK;
    wr(12'h004, {16'hffff, c}, 4'h3);
    rd_chk(12'h004, {16'h0000, ce}, 1'b0);
    `CHK("enables", {ce[10], ce[8], ce[6], ce[2:0]},
         {o_intx_dis, o_serr_en, o_per_en, o_bme, o_mem_en, o_io_en})
    @(posedge i_mclk);
    req_v <= 11'h7ff;
    @(posedge i_mclk);
    req_v <= 11'h000;
    #1;
    `CHK("io_ack", ce[0], o_pri_io_ack)
    `CHK("mem_ack", ce[1], o_pri_mem_ack)
    `CHK("up_own", ce[2], o_up_own)
    `CHK("ur_cpl", ~ce[2], o_ur_cpl)
    `CHK("up_fwd", ce[2], o_up_fwd)
    `CHK("parity", ce[6], o_parity_handle)
    `CHK("fatal", ce[8], o_err_fatal_msg)
    `CHK("nonfatal", ce[8], o_err_nonfatal_msg)
    `CHK("intx_own", ~ce[10], o_intx_own)
    `CHK("intx_fwd", 1'b1, o_intx_fwd)
    @(posedge i_mclk);
    req_v <= 11'h100;
    @(posedge i_mclk);
    req_v <= 11'h000;
    #1;
    `CHK("ur_posted", 1'b0, o_ur_cpl)
    `CHK("fwd_posted", ce[2], o_up_fwd)
    rd_chk(12'h004, {1'b0, ce[8], 5'h00, ce[6], 8'h00, ce}, 1'b0);
    wr(12'h004, 32'h41000000, 4'h8);
    rd_chk(12'h004, {16'h0000, ce}, 1'b0);
  endtask

  task automatic reset_chk();
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    `CHK("enables_rst", {CMD_RST[10], CMD_RST[8], CMD_RST[6], CMD_RST[2:0]},
         {o_intx_dis, o_serr_en, o_per_en, o_bme, o_mem_en, o_io_en})
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    rd_chk(12'h004, {16'h0000, CMD_RST}, 1'b0);
  endtask

  task automatic unmapped_chk();
    wr(12'h008, 32'hffffffff, 4'hf);
    rd_chk(12'h008, 32'h0, 1'b1);
    rd_chk(12'h004, 32'h0, 1'b0);
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    req_v = 11'h000;
    i_rstn = 1'b0;
    repeat (20) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    rd_chk(12'h004, 32'h0, 1'b0);
    req_chk(16'h0000);
    req_chk(16'hffff);
    req_chk(16'h0142);
    req_chk(16'h0405);
    reset_chk();
    req_chk(16'h0000);
    unmapped_chk();
    wrap_up();
  end
endmodule // tb_top
`undef CHK
`default_nettype wire
